//--- logic/hgp_pkg.sv
// Constants, register map and field positions of the handshake GPIO port.
// Assumes a byte-wide processor bus with one-cycle read and write strobes.
//
// Summary of operation
// R1: Eight data pins, each one independently an input or an output; the status instance drives read pulse pin 5 once out of reset.
// R2: Direction bit 1 makes pin n an output; all pins are inputs after reset; the status instance drives pin 5 once out of reset.
// R3: Pull-up enable bit per pin, 1 turns it on; all enabled after reset.
// R4: Control bit 7 flags a detected selected edge on the handshake input.
// R5: Control bit 6 shows the handshake input level, high meaning partner not ready.
// R6: Control bit 5 enables the handshake input interrupt.
// R7: Control bit 4 loops handshake output back onto handshake input for test.
// R8: Control bit 1 sets the handshake output level directly; reset value 1.
// R9: Edge select 1 detects the rising edge of the handshake input.
// R10: The partner drives the handshake input while presenting a byte on the pins.
// R11: The handshake output tells the partner a byte is driven on the pins.
// R12: Each instance decodes a 4-byte window; eight windows are consecutive from the base.
// R13: USB data register read returns the received byte; write passes a byte out.
// R14: USB status byte is the data register of the instance at the status address.
// R15: Software writes USB data only while status bit 7 reads 1.
// R16: Status bit 6 reads 0 while a received byte is waiting.
// R17: Status bit 5 drives the read pulse output toward the USB FIFO.
// R18: Status bit 4 reads 1 normally and 0 after the two-escape reset sequence.
// R19: Status bit 3 reads 1 after enumeration; bits 2 to 0 read 0.
// R20: Edge select 0 detects the falling edge of the handshake input.
// R21: Interrupt request while flag and enable are 1; reading control clears the flag.
// R22: Direction register sits at offset two of the window.
package hgp_pkg;

	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 16;

	// Window layout
	localparam logic [ADDR_W-1:0] PORT_BASE_ADDR = 16'h7e10;
	localparam int unsigned WINDOW_BYTES = 4;
	localparam int unsigned PORT_COUNT = 8;
	localparam logic [ADDR_W-1:0] USB_DATA_ADDR = 16'h7e20;
	localparam logic [ADDR_W-1:0] USB_STATUS_ADDR = 16'h7e24;

	// Offsets inside a window
	localparam logic [1:0] OFS_PIN_VALUES = 2'h0;
	localparam logic [1:0] OFS_PULLUP = 2'h1;
	localparam logic [1:0] OFS_DIRECTION = 2'h2;
	localparam logic [1:0] OFS_CTRL_STATUS = 2'h3;

	// Reset values
	localparam logic [7:0] RST_PIN_VALUES = 8'h00;
	localparam logic [7:0] RST_PULLUP = 8'hff;
	localparam logic [7:0] RST_DIRECTION = 8'h00;
	localparam logic [7:0] RST_CTRL_STATUS = 8'h02;

	// Control/status fields
	localparam int unsigned CS_IRQ_FLAG = 7;
	localparam int unsigned CS_IN_LEVEL = 6;
	localparam int unsigned CS_IRQ_ENABLE = 5;
	localparam int unsigned CS_LOOPBACK = 4;
	localparam int unsigned CS_OUT_LEVEL = 1;
	localparam int unsigned CS_EDGE_SELECT = 0;

	// USB status byte fields
	localparam int unsigned US_TX_SPACE = 7;
	localparam int unsigned US_RX_WAITING_N = 6;
	localparam int unsigned US_READ_PULSE = 5;
	localparam int unsigned US_RESET_N = 4;
	localparam int unsigned US_ENUMERATED = 3;
	localparam logic [7:0] US_UNUSED_MASK = 8'h07;
	localparam logic [7:0] US_DRIVEN_MASK = 8'h20;

	localparam int unsigned RX_FIFO_DEPTH = 16;

endpackage : hgp_pkg

//--- logic/hgp_port.sv
// One handshake GPIO port instance with its receive buffer.
// Assumes pins and the handshake input arrive asynchronously; the bus shares clk_i.
// Eight instances share the bus; only the one whose window matches answers.

module hgp_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int unsigned PW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
			$error("FIFO depth must be a power of two of at least 2");
		end
		if (WIDTH < 1) begin
			$error("FIFO width must be positive");
		end
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW:0] wr_ptr_q;
	logic [PW:0] rd_ptr_q;
	logic full;
	logic empty;
	logic push;
	logic pop;

	// Pointers carry one extra bit so full and empty stay distinct
	assign full = (wr_ptr_q[PW] != rd_ptr_q[PW]) && (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]);
	assign empty = (wr_ptr_q == rd_ptr_q);
	assign push = in_valid_i && !full;
	assign pop = out_ready_i && !empty;
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem_q[rd_ptr_q[PW-1:0]];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_ptr_q[PW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			wr_ptr_q <= '0;
		end else if (push) begin
			wr_ptr_q <= wr_ptr_q + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rd_ptr_q <= '0;
		end else if (pop) begin
			rd_ptr_q <= rd_ptr_q + 1'b1;
		end
	end

endmodule : hgp_fifo

module hgp_port
	import hgp_pkg::*;
#(
	parameter logic [ADDR_W-1:0] BASE_ADDR = PORT_BASE_ADDR,
	parameter bit USB_STATUS_MODE = 1'b0,
	parameter int unsigned FIFO_DEPTH = RX_FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	// Processor bus
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	output logic rvalid_o,
	// Data pins
	input wire logic [DATA_W-1:0] port_pin_i,
	output logic [DATA_W-1:0] port_pin_o,
	output logic [DATA_W-1:0] port_pin_oe_o,
	output logic [DATA_W-1:0] pullup_enable_bits_o,
	// Handshake
	input wire logic handshake_in_i,
	output logic handshake_out_o,
	output logic rx_ready_o,
	output logic irq_o
);

	initial begin
		if (DATA_W != 8) begin
			$error("Port logic serves eight pins only");
		end
		if (BASE_ADDR[1:0] != 2'h0) begin
			$error("Window base must be aligned to four bytes");
		end
	end

	logic [DATA_W-1:0] pin_meta_q;
	logic [DATA_W-1:0] pin_sync_q;
	logic hs_meta_q;
	logic hs_sync_q;
	logic hs_prev_q;
	logic hs_eff;
	logic edge_hit;

	logic [DATA_W-1:0] out_latch_q;
	logic [DATA_W-1:0] pullup_q;
	logic [DATA_W-1:0] dir_q;
	logic irq_flag_q;
	logic irq_en_q;
	logic loopback_q;
	logic out_level_q;
	logic edge_sel_q;

	logic sel;
	logic [1:0] ofs;
	logic wr_hit;
	logic rd_hit;

	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [DATA_W-1:0] fifo_out_data;

	logic [DATA_W-1:0] pin_view;
	logic [DATA_W-1:0] status_view;
	logic [DATA_W-1:0] ctrl_view;
	logic [DATA_W-1:0] rdata_d;

	// Window decode: upper address bits pick the instance, low two the register
	assign sel = (addr_i[ADDR_W-1:2] == BASE_ADDR[ADDR_W-1:2]); // [R12]
	assign ofs = addr_i[1:0];
	assign wr_hit = wr_i && sel;
	assign rd_hit = rd_i && sel;

	// Two-flop synchronisers for the pins and the handshake input
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= port_pin_i;
			pin_sync_q <= pin_meta_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			hs_meta_q <= 1'b1;
			hs_sync_q <= 1'b1;
		end else begin
			hs_meta_q <= handshake_in_i;
			hs_sync_q <= hs_meta_q;
		end
	end

	// Loopback replaces the pin with our own handshake output level
	assign hs_eff = loopback_q ? out_level_q : hs_sync_q; // [R7]

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			hs_prev_q <= 1'b1;
		end else begin
			hs_prev_q <= hs_eff;
		end
	end

	assign edge_hit = edge_sel_q ? (hs_eff && !hs_prev_q) // [R9]
		: (!hs_eff && hs_prev_q); // [R20]

	// Output latch for pins configured as outputs
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			out_latch_q <= RST_PIN_VALUES;
		end else if (wr_hit && ofs == OFS_PIN_VALUES) begin
			out_latch_q <= wdata_i; // [R13] [R17]
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pullup_q <= RST_PULLUP;
		end else if (wr_hit && ofs == OFS_PULLUP) begin
			pullup_q <= wdata_i; // [R3]
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			dir_q <= RST_DIRECTION; // [R2]
		end else if (wr_hit && ofs == OFS_DIRECTION) begin
			dir_q <= wdata_i; // [R22] [R1]
		end
	end

	// Writable control fields
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			irq_en_q <= RST_CTRL_STATUS[CS_IRQ_ENABLE];
			loopback_q <= RST_CTRL_STATUS[CS_LOOPBACK];
			out_level_q <= RST_CTRL_STATUS[CS_OUT_LEVEL]; // [R8]
			edge_sel_q <= RST_CTRL_STATUS[CS_EDGE_SELECT];
		end else if (wr_hit && ofs == OFS_CTRL_STATUS) begin
			irq_en_q <= wdata_i[CS_IRQ_ENABLE]; // [R6]
			loopback_q <= wdata_i[CS_LOOPBACK]; // [R7]
			out_level_q <= wdata_i[CS_OUT_LEVEL]; // [R8] [R11]
			edge_sel_q <= wdata_i[CS_EDGE_SELECT]; // [R9] [R20]
		end
	end

	// Interrupt flag: a new edge in the clearing read's cycle keeps the flag set
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			irq_flag_q <= RST_CTRL_STATUS[CS_IRQ_FLAG];
		end else if (edge_hit) begin
			irq_flag_q <= 1'b1; // [R4]
		end else if (rd_hit && ofs == OFS_CTRL_STATUS) begin
			irq_flag_q <= 1'b0; // [R21]
		end
	end

	// Receive buffer: the partner's strobe edge captures the byte on the pins.
	// A full buffer drops the capture; rx_ready_o tells the partner to hold off.
	assign fifo_in_valid = edge_hit && !USB_STATUS_MODE; // [R10]
	assign fifo_out_ready = rd_hit && ofs == OFS_PIN_VALUES && !USB_STATUS_MODE;

	hgp_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(pin_sync_q),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data)
	);

	// Read views
	assign pin_view = (dir_q & out_latch_q) | (~dir_q & pin_sync_q);

	always_comb begin
		status_view = pin_sync_q & ~US_UNUSED_MASK; // [R19]
		status_view[US_TX_SPACE] = pin_sync_q[US_TX_SPACE]; // [R15]
		status_view[US_RX_WAITING_N] = pin_sync_q[US_RX_WAITING_N]; // [R16]
		status_view[US_READ_PULSE] = out_latch_q[US_READ_PULSE]; // [R17]
		status_view[US_RESET_N] = pin_sync_q[US_RESET_N]; // [R18]
		status_view[US_ENUMERATED] = pin_sync_q[US_ENUMERATED]; // [R19]
	end

	always_comb begin
		ctrl_view = '0;
		ctrl_view[CS_IRQ_FLAG] = irq_flag_q; // [R4]
		ctrl_view[CS_IN_LEVEL] = hs_eff; // [R5]
		ctrl_view[CS_IRQ_ENABLE] = irq_en_q;
		ctrl_view[CS_LOOPBACK] = loopback_q;
		ctrl_view[CS_OUT_LEVEL] = out_level_q;
		ctrl_view[CS_EDGE_SELECT] = edge_sel_q;
	end

	always_comb begin
		rdata_d = '0;
		unique case (ofs)
			OFS_PIN_VALUES: begin
				if (USB_STATUS_MODE) begin
					rdata_d = status_view; // [R14]
				end else if (fifo_out_valid) begin
					rdata_d = fifo_out_data; // [R13]
				end else begin
					rdata_d = pin_view;
				end
			end
			OFS_PULLUP: rdata_d = pullup_q;
			OFS_DIRECTION: rdata_d = dir_q;
			OFS_CTRL_STATUS: rdata_d = ctrl_view;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rdata_o <= '0;
			rvalid_o <= 1'b0;
		end else begin
			rdata_o <= rd_hit ? rdata_d : '0;
			rvalid_o <= rd_hit;
		end
	end

	// Pin drivers; out of reset the status instance always drives the read pulse pin
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			port_pin_o <= RST_PIN_VALUES;
			port_pin_oe_o <= RST_DIRECTION;
			pullup_enable_bits_o <= RST_PULLUP;
		end else begin
			port_pin_o <= out_latch_q;
			port_pin_oe_o <= USB_STATUS_MODE ? (dir_q | US_DRIVEN_MASK) : dir_q; // [R1] [R17]
			pullup_enable_bits_o <= pullup_q; // [R3]
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			handshake_out_o <= RST_CTRL_STATUS[CS_OUT_LEVEL];
			irq_o <= 1'b0;
			rx_ready_o <= 1'b0;
		end else begin
			handshake_out_o <= out_level_q; // [R8] [R11]
			irq_o <= irq_flag_q && irq_en_q; // [R21]
			rx_ready_o <= fifo_in_ready && !USB_STATUS_MODE;
		end
	end

endmodule : hgp_port

//--- tb/hgp_monitor.sv
// Checker for one handshake GPIO port, bound to hgp_port.
// Sees only the port's bus and output pins; shares its clock and reset.
module hgp_monitor
	import hgp_pkg::*;
#(
	parameter logic [ADDR_W-1:0] BASE_ADDR = PORT_BASE_ADDR
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [DATA_W-1:0] rdata_o,
	input wire logic rvalid_o,
	input wire logic [DATA_W-1:0] port_pin_o,
	input wire logic [DATA_W-1:0] port_pin_oe_o,
	input wire logic [DATA_W-1:0] pullup_enable_bits_o,
	input wire logic handshake_out_o,
	input wire logic irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	logic hit;
	logic en_q;
	assign hit = addr_i[15:2] == BASE_ADDR[15:2];
	// Shadow of the enable bit, so irq can be judged without the body
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			en_q <= 1'b0;
		end else if (wr_i && hit && addr_i[1:0] == OFS_CTRL_STATUS) begin
			en_q <= wdata_i[CS_IRQ_ENABLE];
		end
	end
	a_read_answer: assert property (rd_i && hit |=> rvalid_o)
		else $error("read got no answer");
	a_no_stray: assert property (!(rd_i && hit) |=> !rvalid_o)
		else $error("answer without a read");
	// Pin outputs are registered from the register, so a write shows two edges later
	a_dir_write: assert property (wr_i && hit && addr_i[1:0] == OFS_DIRECTION
		|-> ##2 port_pin_oe_o == $past(wdata_i, 2)) else $error("direction not applied");
	a_pullup_write: assert property (wr_i && hit && addr_i[1:0] == OFS_PULLUP
		|-> ##2 pullup_enable_bits_o == $past(wdata_i, 2)) else $error("pull-up not applied");
	a_pin_latch: assert property (wr_i && hit && addr_i[1:0] == OFS_PIN_VALUES
		|-> ##2 port_pin_o == $past(wdata_i, 2)) else $error("pin latch not applied");
	a_out_level: assert property (wr_i && hit && addr_i[1:0] == OFS_CTRL_STATUS
		|-> ##2 handshake_out_o == $past(wdata_i[CS_OUT_LEVEL], 2)) else $error("handshake level wrong");
	a_irq_gated: assert property (irq_o |-> $past(en_q))
		else $error("irq while disabled");
	a_ctrl_zero: assert property (rvalid_o && $past(addr_i[1:0]) == OFS_CTRL_STATUS
		|-> rdata_o[3:2] == 2'h0) else $error("unused control bits set");
endmodule : hgp_monitor

bind hgp_port hgp_monitor #(.BASE_ADDR(BASE_ADDR)) u_mon (
	.clk_i(clk_i),
	.resetn_i(resetn_i),
	.addr_i(addr_i),
	.wdata_i(wdata_i),
	.wr_i(wr_i),
	.rd_i(rd_i),
	.rdata_o(rdata_o),
	.rvalid_o(rvalid_o),
	.port_pin_o(port_pin_o),
	.port_pin_oe_o(port_pin_oe_o),
	.pullup_enable_bits_o(pullup_enable_bits_o),
	.handshake_out_o(handshake_out_o),
	.irq_o(irq_o)
);

//--- tb/hgp_host_model.sv
// Parallel host that strobes bytes into the port.
// Runs on the bench clock; handshake idles high.
module hgp_host_model (
	input wire logic clk_i,
	output logic [7:0] pin_o,
	output logic hs_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		pin_o = 8'h5a;
		hs_o = 1'b1;
	end
	// Byte held 4 cycles around both strobe edges, then scrambled
	task automatic send(input logic [7:0] b, input int gap);
		pin_o = b;
		repeat (4) @(posedge clk_i);
		#1 hs_o = 1'b0;
		repeat (4 + gap) @(posedge clk_i);
		#1 hs_o = 1'b1;
		repeat (4) @(posedge clk_i);
		#1 pin_o = ~b;
	endtask : send
endmodule : hgp_host_model

//--- tb/tb_top.sv
// Self-checking bench for two handshake GPIO port instances, one of them in USB status mode.
// Assumes the host model and bound checker are compiled alongside.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import hgp_pkg::*;
	localparam logic [15:0] base = 16'h7e10;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] rdata_o, pin_i, pin_o, oe, pu, d, v8, p;
	logic rvalid_o, hs, handshake_out, rxr, irq, v;
	logic [7:0] usb_rdata, usb_pin_o, usb_oe;
	logic [7:0] usb_pin = 8'hff;
	logic usb_rvalid;
	logic [7:0] q[$];
	int errors = 0;
	int checks = 0;
	logic [15:0] lfsr = 16'h51b9;
	always #2.5 clk_i = ~clk_i;
	hgp_port #(.BASE_ADDR(base), .USB_STATUS_MODE(1'b0), .FIFO_DEPTH(16)) u_dut (
		.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
		.port_pin_i(pin_i), .port_pin_o(pin_o), .port_pin_oe_o(oe), .pullup_enable_bits_o(pu),
		.handshake_in_i(hs), .handshake_out_o(handshake_out), .rx_ready_o(rxr), .irq_o(irq));
	hgp_host_model u_host (.clk_i(clk_i), .pin_o(pin_i), .hs_o(hs));
	// Status instance shares the bus; idle instances answer zero, so read data is ORed
	hgp_port #(.BASE_ADDR(USB_STATUS_ADDR), .USB_STATUS_MODE(1'b1), .FIFO_DEPTH(16)) u_usb_dut (
		.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(usb_rdata), .rvalid_o(usb_rvalid),
		.port_pin_i(usb_pin), .port_pin_o(usb_pin_o), .port_pin_oe_o(usb_oe), .pullup_enable_bits_o(),
		.handshake_in_i(hs), .handshake_out_o(), .rx_ready_o(), .irq_o());
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction : rnd
	function automatic logic [7:0] pin_read(logic [7:0] dir, logic [7:0] lat, logic [7:0] pins);
		return (dir & lat) | (~dir & pins);
	endfunction : pin_read
	function automatic logic [7:0] usb_view(logic [7:0] pins, logic [7:0] lat);
		return {pins[7:6], lat[5], pins[4:3], 3'h0};
	endfunction : usb_view
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp
	// Idle cycle after each strobe keeps strobes from being reassigned in one step
	task automatic wr(input logic [15:0] a, input logic [7:0] dat);
		addr_i = a;
		wdata_i = dat;
		wr_i = 1'b1;
		@(posedge clk_i) #1;
		wr_i = 1'b0;
		@(posedge clk_i) #1;
	endtask : wr
	task automatic rd(input logic [15:0] a);
		addr_i = a;
		rd_i = 1'b1;
		@(posedge clk_i) #1;
		rd_i = 1'b0;
		v = rvalid_o | usb_rvalid;
		d = rdata_o | usb_rdata;
		@(posedge clk_i) #1;
	endtask : rd
	task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
		rd(a);
		cmp({7'h00, v}, 8'h01);
		cmp(d, e);
	endtask : rdchk
	task automatic conclude();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	initial begin
		#200us;
		errors++;
		conclude();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		#1 resetn_i = 1'b1;
		repeat (3) @(posedge clk_i);
		#1 rdchk(base + 16'h1, 8'hff);
		rdchk(base + 16'h2, 8'h00);
		rdchk(base + 16'h3, 8'h42);
		rdchk(base, 8'h5a);
		cmp({7'h00, handshake_out}, 8'h01);
		rd(16'h7e14);
		cmp({7'h00, v}, 8'h00);
		rd(16'h7e0f);
		cmp({7'h00, v}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v8 = rnd();
			p = rnd();
			wr(base + 16'h2, lfsr[15:8]);
			wr(base, v8);
			wr(base + 16'h1, p);
			cmp(oe, lfsr[15:8]);
			cmp(pu, p);
			cmp(pin_o, v8);
			rdchk(base, pin_read(lfsr[15:8], v8, 8'h5a));
		end
		wr(base + 16'h2, 8'h00);
		wr(base + 16'h3, 8'hcd);
		cmp({7'h00, handshake_out}, 8'h00);
		rdchk(base + 16'h3, 8'h41);
		wr(base + 16'h3, 8'h32);
		rdchk(base + 16'h3, 8'h72);
		wr(base + 16'h3, 8'h30);
		repeat (4) @(posedge clk_i);
		#1 cmp({7'h00, irq}, 8'h01);
		rdchk(base + 16'h3, 8'hb0);
		rdchk(base + 16'h3, 8'h30);
		cmp({7'h00, irq}, 8'h00);
		rdchk(base, 8'h5a);
		// Raise the looped level before leaving loopback, else the pin's idle high is a false edge
		wr(base + 16'h3, 8'h12);
		wr(base + 16'h3, 8'h03);
		for (int i = 0; i < 17; i++) begin
			p = rnd();
			if (i < 16) begin
				q.push_back(p);
			end
			u_host.send(p, (i % 2) * int'(p[1:0]));
			if (i == 15) begin
				cmp({7'h00, rxr}, 8'h00);
			end
		end
		rdchk(base + 16'h3, 8'hc3);
		cmp({7'h00, irq}, 8'h00);
		foreach (q[i]) begin
			rdchk(base, q[i]);
		end
		rdchk(base, ~p);
		cmp({7'h00, rxr}, 8'h01);
		usb_pin = 8'hdf;
		wr(USB_STATUS_ADDR, 8'h20);
		repeat (2) @(posedge clk_i);
		#1 rdchk(USB_STATUS_ADDR, usb_view(8'hdf, 8'h20));
		cmp(usb_oe, 8'h20);
		cmp(usb_pin_o, 8'h20);
		usb_pin = 8'h27;
		repeat (3) @(posedge clk_i);
		#1 rdchk(USB_STATUS_ADDR, usb_view(8'h27, 8'h20));
		wr(USB_STATUS_ADDR, 8'h00);
		rdchk(USB_STATUS_ADDR, usb_view(8'h27, 8'h00));
		conclude();
	end
endmodule : tb_top
